// *** hw/motion_cmd_pkg.sv ***
// constants and types for the motion command executor
// What this block does
// RQ1 - address byte: 11, four node bits, pin bit, then read/write bit
// RQ2 - second byte is the command code (0x81, 0x82, 0x84..0x88)
// RQ3 - one-time read answers eight memory words, word 0 first
// RQ4 - park command, own or broadcast, moves to the eleven-bit park position
// RQ5 - park position 0x400 means disabled: park commands are ignored
// RQ6 - a coil fault halts internally and switches both bridges off
// RQ7 - coil fault halt while moving sets the lost-steps flag
// RQ8 - a halt command from the host acts like the internal halt
// RQ9 - zero command clears actual and target position
// RQ10 - zero command is ignored while the motor moves
// RQ11 - reload command rewrites parameter memory with reset values
// RQ12 - reload keeps actual position and copies it into target
// RQ13 - search: move to first target, slow move to second, zero, park
// RQ14 - during a search other commands are refused, except halt or shutdown
// RQ15 - search skips the final park when park position is 0x400
// RQ16 - host sends search only with distinct targets from start and each other
// RQ17 - bad search targets deadlock until halt then full status read
// RQ18 - search frame: two 0xff bytes, velocity nibbles, two targets high first
// RQ19 - frames for other addresses are ignored and get no answer
package motion_cmd_pkg;
	localparam logic [7:0] CMD_FULL_STATUS = 8'h81;
	localparam logic [7:0] CMD_READ_OTP = 8'h82;
	localparam logic [7:0] CMD_PARK = 8'h84;
	localparam logic [7:0] CMD_HALT = 8'h85;
	localparam logic [7:0] CMD_ZERO = 8'h86;
	localparam logic [7:0] CMD_RELOAD = 8'h87;
	localparam logic [7:0] CMD_SEARCH = 8'h88;
	localparam logic [1:0] ADDR_TOP = 2'h3;
	localparam logic [6:0] BCAST_ADDR = 7'h00;
	localparam logic [10:0] PARK_DISABLED = 11'h400;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	// bit counter positions within a byte, and byte counter limits
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] MAX_BYTE = 4'h8;
	localparam logic [3:0] OTP_WORDS = 4'h8;
	// byte positions within a command frame
	localparam int B_CMD = 1;
	localparam int B_VEL = 4;
	localparam int B_T1H = 5;
	localparam int B_T1L = 6;
	localparam int B_T2H = 7;
	localparam int B_T2L = 8;
	// values after reset; the speeds also after reload
	localparam logic [3:0] DEF_VMAX = 4'h0;
	localparam logic [3:0] DEF_VMIN = 4'h0;
	localparam logic [15:0] RST_TARGET = 16'h0000;
	typedef struct packed {
		logic [15:0] target;
		logic [3:0] vmax;
		logic [3:0] vmin;
	} motion_req_type;
	typedef logic [7:0][7:0] otp_image_type;
	typedef enum {
		C_IDLE, C_WAIT1, C_WAIT2, C_PARK, C_WAIT3, C_DEADLOCK, C_DEAD_HALTED
	} cmd_state_type;
endpackage

// *** hw/motion_command_executor.sv ***
// two-wire command decoder and executor for the motion core
`timescale 1ns/1ps
`default_nettype none
module motion_command_executor import motion_cmd_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// two-wire serial link, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// node address
	input wire logic [3:0] node_addr_prog,
	input wire logic hardwired_addr_pin,
	// one-time memory image, word 0 in index 0
	input wire otp_image_type otp_image,
	// motion core side
	input wire logic [15:0] actual_position,
	input wire logic moving,
	input wire logic [10:0] safe_park_position,
	input wire logic coil_fault_a,
	input wire logic coil_fault_b,
	input wire logic motor_shutdown,
	// commands to the motion core
	output motion_req_type motion,
	output logic move_req,
	output logic bridges_off,
	output logic position_clear,
	output logic defaults_reload,
	// status
	output logic lost_steps_flag,
	output logic search_busy,
	output logic deadlock
);
	function automatic logic [15:0] park_target(input logic [10:0] p);
		return {{5{p[10]}}, p};
	endfunction

	function automatic logic park_enabled(input logic [10:0] p);
		return p != PARK_DISABLED;
	endfunction

	// link pins pass two flops before use
	logic [1:0] scl_s, sda_s, hw_s;
	logic scl_d, sda_d;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			hw_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			hw_s <= {hw_s[0], hardwired_addr_pin};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s[1] & ~scl_d;
	assign scl_fall = ~scl_s[1] & scl_d;
	assign bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	assign bus_stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];

	// link state
	logic [3:0] bitcnt, next_bitcnt, bytecnt, next_bytecnt;
	logic [7:0] shreg, next_shreg, tx, next_tx;
	logic listen, next_listen, matched, next_matched;
	logic rd, next_rd, bcast, next_bcast, nacked, next_nacked;
	logic read_armed, next_read_armed, next_sda_oe;
	logic first_fall, next_first_fall;
	logic cmd_valid, next_cmd_valid;
	logic [7:0] cmd_code, next_cmd_code;
	logic [7:0] frame [1:8];
	logic [7:0] next_frame [1:8];
	cmd_state_type state, next_state;
	logic [6:0] own_addr;
	assign own_addr = {ADDR_TOP, node_addr_prog, hw_s[1]};

	// byte framing, address match, acknowledge and read data
	always_comb begin
		next_bitcnt = bitcnt;
		next_bytecnt = bytecnt;
		next_shreg = shreg;
		next_tx = tx;
		next_listen = listen;
		next_matched = matched;
		next_rd = rd;
		next_bcast = bcast;
		next_nacked = nacked;
		next_read_armed = read_armed;
		next_first_fall = first_fall;
		next_sda_oe = sda_oe;
		next_cmd_valid = 1'b0;
		next_cmd_code = cmd_code;
		next_frame = frame;
		if (bus_start) begin
			next_bitcnt = 4'h0;
			next_bytecnt = 4'h0;
			next_listen = 1'b1;
			next_first_fall = 1'b1;
			next_matched = 1'b0;
			next_rd = 1'b0;
			next_nacked = 1'b0;
			next_sda_oe = 1'b0;
		end else if (bus_stop) begin
			next_listen = 1'b0;
			next_sda_oe = 1'b0;
			// broadcast only carries the park command
			if (listen && matched && !rd && bytecnt >= 4'h2 &&
			    (!bcast || frame[B_CMD] == CMD_PARK)) begin
				next_cmd_valid = 1'b1;
				next_cmd_code = frame[B_CMD];
			end
			if (listen && matched && rd)
				next_read_armed = 1'b0;
		end else if (listen && scl_rise) begin
			if (bitcnt < ACK_SLOT)
				next_shreg = {shreg[6:0], sda_s[1]};
			else if (rd && sda_s[1])
				next_nacked = 1'b1;
		end else if (listen && scl_fall) begin
			// the fall that ends a start carries no bit, so skip it
			if (first_fall) begin
				next_first_fall = 1'b0;
			end else if (bitcnt < LAST_BIT) begin
				next_bitcnt = bitcnt + 4'h1;
				if (matched && rd && !nacked) begin
					next_sda_oe = ~tx[7];
					next_tx = {tx[6:0], 1'b1};
				end
			end else if (bitcnt == LAST_BIT) begin
				next_bitcnt = ACK_SLOT;
				next_sda_oe = 1'b0;
				if (bytecnt == 4'h0) begin
					// RQ1 address check
					// RQ19 foreign address stays silent
					if (shreg[7:1] == own_addr ||
					    (shreg[7:1] == BCAST_ADDR && !shreg[0])) begin
						next_matched = 1'b1;
						next_rd = shreg[0];
						next_bcast = shreg[7:1] == BCAST_ADDR;
						next_sda_oe = 1'b1;
					end
				end else if (matched && !rd) begin
					if (bytecnt <= MAX_BYTE)
						next_frame[bytecnt] = shreg;
					next_sda_oe = 1'b1;
				end
			end else begin
				next_bitcnt = 4'h0;
				next_sda_oe = 1'b0;
				if (bytecnt != 4'hf)
					next_bytecnt = bytecnt + 4'h1;
				// RQ3 words sent in address order
				if (matched && rd && !nacked) begin
					next_tx = IDLE_BYTE;
					if (read_armed && bytecnt < OTP_WORDS)
						next_tx = otp_image[bytecnt[2:0]];
					next_sda_oe = ~next_tx[7];
					next_tx = {next_tx[6:0], 1'b1};
				end
			end
		end
		// RQ14 read not armed while searching
		if (cmd_valid && cmd_code == CMD_READ_OTP && state == C_IDLE)
			next_read_armed = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bitcnt <= 4'h0;
			bytecnt <= 4'h0;
			shreg <= 8'h00;
			tx <= IDLE_BYTE;
			listen <= 1'b0;
			matched <= 1'b0;
			rd <= 1'b0;
			bcast <= 1'b0;
			nacked <= 1'b0;
			read_armed <= 1'b0;
			first_fall <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_code <= 8'h00;
			for (int i = 1; i <= 8; i++)
				frame[i] <= 8'h00;
		end else begin
			bitcnt <= next_bitcnt;
			bytecnt <= next_bytecnt;
			shreg <= next_shreg;
			tx <= next_tx;
			listen <= next_listen;
			matched <= next_matched;
			rd <= next_rd;
			bcast <= next_bcast;
			nacked <= next_nacked;
			read_armed <= next_read_armed;
			first_fall <= next_first_fall;
			sda_oe <= next_sda_oe;
			sda_out <= 1'b0; // open drain: only ever pulls low
			cmd_valid <= next_cmd_valid;
			cmd_code <= next_cmd_code;
			frame <= next_frame;
		end
	end

	// command execution and reference search
	logic [15:0] search_first_target, search_second_target;
	logic [15:0] second_t, next_second_t;
	logic [3:0] slow_v, next_slow_v;
	logic fault, halt_cmd, arrived, in_search;
	motion_req_type next_motion;
	logic next_move_req, next_bridges_off, next_position_clear;
	logic next_defaults_reload, next_lost;
	assign search_first_target = {frame[B_T1H], frame[B_T1L]};
	assign search_second_target = {frame[B_T2H], frame[B_T2L]};
	assign fault = coil_fault_a | coil_fault_b;
	assign halt_cmd = cmd_valid && cmd_code == CMD_HALT;
	assign arrived = !moving && actual_position == motion.target;
	assign in_search = state == C_WAIT1 || state == C_WAIT2 ||
		state == C_PARK || state == C_WAIT3;

	always_comb begin
		next_state = state;
		next_motion = motion;
		next_second_t = second_t;
		next_slow_v = slow_v;
		next_move_req = 1'b0;
		next_position_clear = 1'b0;
		next_defaults_reload = 1'b0;
		next_bridges_off = bridges_off;
		// clear first so a fault in the same cycle wins
		next_lost = lost_steps_flag &
			~(cmd_valid && cmd_code == CMD_FULL_STATUS);
		if (fault || halt_cmd) begin
			// RQ6 RQ8 bridges off, search aborted
			next_bridges_off = 1'b1;
			// RQ7 steps may be lost
			if (fault && moving)
				next_lost = 1'b1;
			// RQ17 halt is first step out of deadlock
			if (state == C_DEADLOCK)
				next_state = halt_cmd ? C_DEAD_HALTED : C_DEADLOCK;
			else if (state != C_DEAD_HALTED)
				next_state = C_IDLE;
		end else if (motor_shutdown && in_search) begin
			// RQ14 shutdown aborts the search
			next_state = C_IDLE;
		end else begin
			case (state)
			C_IDLE: begin
				if (cmd_valid) begin
					// RQ2 command code decode
					case (cmd_code)
					CMD_PARK: begin
						// RQ4 RQ5 park unless disabled
						if (park_enabled(safe_park_position)) begin
							next_motion.target =
								park_target(safe_park_position);
							next_move_req = 1'b1;
							next_bridges_off = 1'b0;
						end
					end
					CMD_ZERO: begin
						// RQ9 RQ10 only at standstill
						if (!moving) begin
							next_position_clear = 1'b1;
							next_motion.target = RST_TARGET;
						end
					end
					CMD_RELOAD: begin
						// RQ11 RQ12 reload, hold position
						next_defaults_reload = 1'b1;
						next_motion.target = actual_position;
						next_motion.vmax = DEF_VMAX;
						next_motion.vmin = DEF_VMIN;
					end
					CMD_SEARCH: begin
						// RQ17 equal targets would never arrive
						if (search_first_target == actual_position ||
						    search_second_target == search_first_target)
							next_state = C_DEADLOCK;
						else begin
							// RQ13 RQ18 first leg at commanded speeds
							next_motion.target = search_first_target;
							next_motion.vmax = frame[B_VEL][7:4];
							next_motion.vmin = frame[B_VEL][3:0];
							next_second_t = search_second_target;
							next_slow_v = frame[B_VEL][3:0];
							next_move_req = 1'b1;
							next_bridges_off = 1'b0;
							next_state = C_WAIT1;
						end
					end
					default: begin
					end
					endcase
				end
			end
			C_WAIT1: begin
				// RQ13 second leg at minimum speed
				if (arrived) begin
					next_motion.target = second_t;
					next_motion.vmax = slow_v;
					next_move_req = 1'b1;
					next_state = C_WAIT2;
				end
			end
			C_WAIT2: begin
				// RQ13 zero the position
				if (arrived) begin
					next_position_clear = 1'b1;
					next_motion.target = RST_TARGET;
					next_state = C_PARK;
				end
			end
			C_PARK: begin
				// RQ15 final park skipped when disabled
				if (park_enabled(safe_park_position)) begin
					next_motion.target = park_target(safe_park_position);
					next_move_req = 1'b1;
					next_state = C_WAIT3;
				end else
					next_state = C_IDLE;
			end
			C_WAIT3: begin
				if (arrived)
					next_state = C_IDLE;
			end
			C_DEADLOCK: begin
			end
			C_DEAD_HALTED: begin
				// RQ17 full status read releases deadlock
				if (cmd_valid && cmd_code == CMD_FULL_STATUS)
					next_state = C_IDLE;
			end
			default: next_state = C_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= C_IDLE;
			motion <= '{RST_TARGET, DEF_VMAX, DEF_VMIN};
			second_t <= RST_TARGET;
			slow_v <= DEF_VMIN;
			move_req <= 1'b0;
			bridges_off <= 1'b0;
			position_clear <= 1'b0;
			defaults_reload <= 1'b0;
			lost_steps_flag <= 1'b0;
			search_busy <= 1'b0;
			deadlock <= 1'b0;
		end else begin
			state <= next_state;
			motion <= next_motion;
			second_t <= next_second_t;
			slow_v <= next_slow_v;
			move_req <= next_move_req;
			bridges_off <= next_bridges_off;
			position_clear <= next_position_clear;
			defaults_reload <= next_defaults_reload;
			lost_steps_flag <= next_lost;
			search_busy <= next_state inside {C_WAIT1, C_WAIT2,
				C_PARK, C_WAIT3};
			deadlock <= next_state inside {C_DEADLOCK, C_DEAD_HALTED};
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic calm;
	assign calm = cmd_valid && !fault && state == C_IDLE;
	// the search's own zeroing step may meet a refused command
	logic zero_step;
	assign zero_step = state == C_WAIT2 && arrived && !motor_shutdown;
	sequence search_go;
		calm && cmd_code == CMD_SEARCH && search_first_target !=
			actual_position && search_second_target != search_first_target;
	endsequence
	sequence first_leg;
		move_req && search_busy && motion.target == $past(search_first_target);
	endsequence
	a_park_moves: assert property (calm && cmd_code == CMD_PARK && // RQ4
		park_enabled(safe_park_position) |=> move_req &&
		motion.target[10:0] == $past(safe_park_position))
		else $error("park command did not move");
	a_park_off: assert property (calm && cmd_code == CMD_PARK && // RQ5
		!park_enabled(safe_park_position) |=> !move_req)
		else $error("disabled park moved");
	a_fault_halt: assert property (fault |=> bridges_off) // RQ6
		else $error("coil fault left bridges on");
	a_lost_steps: assert property (fault && moving |=> // RQ7
		lost_steps_flag) else $error("lost steps not flagged");
	a_cmd_halt: assert property (halt_cmd |=> bridges_off && // RQ8
		!search_busy) else $error("halt command not obeyed");
	a_zero_pos: assert property (calm && cmd_code == CMD_ZERO && // RQ9
		!moving |=> position_clear && motion.target == RST_TARGET)
		else $error("zero command not executed");
	a_zero_moving: assert property (cmd_code == CMD_ZERO && // RQ10
		cmd_valid && moving |=> !position_clear)
		else $error("zero executed while moving");
	a_reload_keep: assert property (calm && cmd_code == // RQ12
		CMD_RELOAD |=> defaults_reload &&
		motion.target == $past(actual_position))
		else $error("reload lost position");
	a_search_start: assert property (search_go |=> first_leg) // RQ13
		else $error("search first leg missing");
	a_search_reject: assert property (search_busy && cmd_valid && // RQ14
		cmd_code != CMD_HALT && !fault |=> !defaults_reload &&
		position_clear == $past(zero_step))
		else $error("command accepted in search");
	a_skip_park: assert property (state == C_PARK && !fault && // RQ15
		!halt_cmd && !motor_shutdown && !park_enabled(safe_park_position)
		|=> !move_req && !search_busy) else $error("disabled park run");
	a_dead_lock: assert property (calm && cmd_code == CMD_SEARCH && // RQ17
		(search_first_target == actual_position ||
		search_second_target == search_first_target) |=> deadlock ##1
		(deadlock || halt_cmd || $past(halt_cmd)))
		else $error("bad search did not deadlock");
endmodule
`default_nettype wire

// *** tb/host_master_model.sv ***
// two-wire bus master model standing in for the host
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
	// clock
	input wire logic clk,
	// bus wires, open drain
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	logic bit_in;
	// bus idles released, clock stands high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// quarter of the 800 ns bus period
	task automatic q();
		repeat (2) @(posedge clk);
	endtask
	task automatic start();
		sda_low <= 1'b1;
		q();
		scl <= 1'b0;
	endtask
	// data moves mid-low, sampled mid-high, well after the slave's 3 clk
	task automatic clk_bit(input logic b);
		q();
		sda_low <= !b;
		q();
		scl <= 1'b1;
		q();
		bit_in = sda_wire;
		q();
		scl <= 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(v[i]);
		clk_bit(1'b1);
		ack = !bit_in;
	endtask
	// last byte gets a nack so the slave stops sending
	task automatic get_byte(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1);
			v[i] = bit_in;
		end
		clk_bit(last);
	endtask
	task automatic stop();
		q();
		sda_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b0;
		q();
	endtask
endmodule
`default_nettype wire

// *** tb/motion_command_executor_tb.sv ***
// self-checking bench for the motion command executor
`timescale 1ns/1ps
`default_nettype none
module motion_command_executor_tb import motion_cmd_pkg::*; ;
	localparam logic [7:0] ADR_W = 8'hea;
	localparam logic [63:0] OTP_VAL = 64'h8877665544332211;
	logic clk, arst_n, scl, host_low, sda_out, sda_oe, sda_wire, acked;
	logic moving, coil_fault_a, move_req, bridges_off, bo_q;
	logic coil_fault_b, motor_shutdown;
	logic position_clear, defaults_reload, lost_steps_flag;
	logic search_busy, deadlock;
	logic [15:0] actual_position;
	logic [10:0] safe_park_position;
	motion_req_type motion;
	logic [7:0] moves, clears, reloads;
	logic [15:0] mv_t [16];
	logic [7:0] mv_v [16];
	int travel, left, fails, check_count;
	// pull-up: low when either side drives
	assign sda_wire = !host_low && !(sda_oe && !sda_out);
	host_master_model u_host_master_model (.clk(clk), .sda_wire(sda_wire),
		.scl(scl), .sda_low(host_low));
	motion_command_executor u_motion_command_executor (.clk(clk),
		.arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .node_addr_prog(4'ha), .hardwired_addr_pin(1'b1),
		.otp_image(OTP_VAL), .actual_position(actual_position),
		.moving(moving), .safe_park_position(safe_park_position),
		.coil_fault_a(coil_fault_a), .coil_fault_b(coil_fault_b),
		.motor_shutdown(motor_shutdown), .motion(motion),
		.move_req(move_req),
		.bridges_off(bridges_off), .position_clear(position_clear),
		.defaults_reload(defaults_reload), .lost_steps_flag(lost_steps_flag),
		.search_busy(search_busy), .deadlock(deadlock));
	initial begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	// motion core stand-in; a halt edge stops it short of the target
	always @(posedge clk) begin
		bo_q <= bridges_off;
		if (move_req === 1'b1) begin
			mv_t[moves[3:0]] <= motion.target;
			mv_v[moves[3:0]] <= {motion.vmax, motion.vmin};
			moves <= moves + 8'h01;
			left <= travel;
			moving <= 1'b1;
		end else if (bridges_off === 1'b1 && bo_q !== 1'b1) begin
			moving <= 1'b0;
		end else if (left > 1) begin
			left <= left - 1;
		end else if (moving) begin
			moving <= 1'b0;
			actual_position <= motion.target;
		end
		if (position_clear === 1'b1) begin
			clears <= clears + 8'h01;
			actual_position <= 16'h0000;
		end
		if (defaults_reload === 1'b1)
			reloads <= reloads + 8'h01;
	end
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// write frame: address then n payload bytes, first byte on top
	task automatic send(input logic [7:0] adr, input int n,
		input logic [63:0] pay);
		logic d;
		u_host_master_model.start();
		u_host_master_model.put_byte(adr, acked);
		for (int i = 0; i < n; i++)
			u_host_master_model.put_byte(pay[63-8*i -: 8], d);
		u_host_master_model.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic cmd(input logic [7:0] c);
		send(ADR_W, 1, {c, 56'h0});
	endtask
	// bounded wait for the motor and any search to come to rest
	task automatic settle();
		int k;
		k = 0;
		while ((moving !== 1'b0 || search_busy !== 1'b0) && k < 5000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 5000) begin
			fails++;
			$display("Error settle expected 0 seen 1");
			test_done();
		end
		repeat (4) @(posedge clk);
	endtask
	initial begin
		logic [7:0] v;
		logic [7:0] m0;
		logic [7:0] c0;
		fails = 0;
		check_count = 0;
		arst_n = 1'b0;
		moving = 1'b0;
		coil_fault_a = 1'b0;
		coil_fault_b = 1'b0;
		motor_shutdown = 1'b0;
		actual_position = 16'h0000;
		safe_park_position = 11'h7f0;
		moves = 8'h00;
		clears = 8'h00;
		reloads = 8'h00;
		travel = 20;
		left = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// one-time words come back in address order
		cmd(CMD_READ_OTP);
		chk("addr ack", 16'h1, acked);
		u_host_master_model.start();
		u_host_master_model.put_byte(ADR_W | 8'h01, acked);
		for (int i = 0; i < 8; i++) begin
			u_host_master_model.get_byte(i == 7, v);
			chk("otp word", OTP_VAL[8*i +: 8], v);
		end
		u_host_master_model.stop();
		$display("test otp read done");
		send(8'he8, 1, {CMD_HALT, 56'h0});
		chk("foreign ack", 16'h0, acked);
		chk("foreign halt", 16'h0, bridges_off);
		$display("test foreign address done");
		cmd(CMD_PARK);
		chk("park moves", 16'h1, moves);
		chk("park target", 16'hfff0, motion.target);
		settle();
		send(8'h00, 1, {CMD_PARK, 56'h0});
		chk("bcast moves", 16'h2, moves);
		settle();
		safe_park_position <= 11'h400;
		cmd(CMD_PARK);
		chk("disabled moves", 16'h2, moves);
		$display("test park done");
		// long moves so later frames land mid-motion
		travel = 400;
		safe_park_position <= 11'h010;
		cmd(CMD_PARK);
		cmd(CMD_ZERO);
		chk("zero moving", 16'h0, clears);
		settle();
		cmd(CMD_ZERO);
		chk("zero rest", 16'h1, clears);
		chk("zero target", 16'h0, motion.target);
		$display("test zero done");
		actual_position <= 16'h1234;
		cmd(CMD_RELOAD);
		chk("reloads", 16'h1, reloads);
		chk("reload target", 16'h1234, motion.target);
		chk("reload speed", 16'h0, {motion.vmax, motion.vmin});
		$display("test reload done");
		cmd(CMD_PARK);
		cmd(CMD_HALT);
		chk("halt bridges", 16'h1, bridges_off);
		cmd(CMD_PARK);
		coil_fault_a <= 1'b1;
		repeat (3) @(posedge clk);
		chk("fault bridges", 16'h1, bridges_off);
		chk("lost steps", 16'h1, lost_steps_flag);
		coil_fault_a <= 1'b0;
		settle();
		cmd(CMD_PARK);
		coil_fault_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk("fault b bridges", 16'h1, bridges_off);
		coil_fault_b <= 1'b0;
		settle();
		$display("test halt and fault done");
		// search with park disabled; zero mid-search must be refused
		travel = 300;
		safe_park_position <= 11'h400;
		m0 = moves;
		c0 = clears;
		send(ADR_W, 8, {CMD_SEARCH, 16'hffff, 8'h53, 32'h01000050});
		chk("search busy", 16'h1, search_busy);
		cmd(CMD_ZERO);
		cmd(CMD_RELOAD);
		settle();
		chk("search reload", 16'h1, reloads);
		chk("search moves", {8'h0, m0 + 8'h02}, moves);
		chk("first target", 16'h0100, mv_t[m0[3:0]]);
		chk("first speed", 16'h53, mv_v[m0[3:0]]);
		chk("second target", 16'h0050, mv_t[m0[3:0] + 4'h1]);
		chk("second speed", 16'h33, mv_v[m0[3:0] + 4'h1]);
		chk("search clears", {8'h0, c0 + 8'h01}, clears);
		$display("test search done");
		// first target equal to the actual position deadlocks
		send(ADR_W, 8, {CMD_SEARCH, 16'hffff, 8'h53, 32'h00000050});
		chk("deadlock", 16'h1, deadlock);
		cmd(CMD_FULL_STATUS);
		chk("status only", 16'h1, deadlock);
		chk("lost cleared", 16'h0, lost_steps_flag);
		cmd(CMD_HALT);
		cmd(CMD_FULL_STATUS);
		chk("deadlock left", 16'h0, deadlock);
		$display("test deadlock done");
		// shutdown aborts a running search
		send(ADR_W, 8, {CMD_SEARCH, 16'hffff, 8'h53, 32'h01000050});
		motor_shutdown <= 1'b1;
		repeat (3) @(posedge clk);
		chk("shutdown abort", 16'h0, search_busy);
		motor_shutdown <= 1'b0;
		settle();
		$display("test shutdown done");
		test_done();
	end
endmodule
`default_nettype wire
